// *** design/srl_pkg.sv ***
/*
  Constants, types and helpers shared by the serial port framing block.
  Assumes a single 10 MHz core clock and a host that drives SCLK in mode 3.
*/
package srl_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int REL_DELAY_NS = 400;
  localparam int REL_CYC = (REL_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Command and register map
  // ----------------------------------------------------------------
  localparam int CMD_BITS = 8;
  localparam int CMD_READ_POS = 6;
  localparam logic [5:0] ADDR_STATUS = 6'h00;
  localparam logic [5:0] ADDR_CTRL = 6'h01;
  localparam logic [5:0] ADDR_DATA = 6'h02;
  localparam logic [5:0] ADDR_ERROR = 6'h03;
  localparam int W_BYTE = 8;
  localparam int W_CTRL = 16;
  localparam int W_DATA = 24;
  localparam int W_SHIFT = 32;

  // ----------------------------------------------------------------
  // Converter control word fields
  // ----------------------------------------------------------------
  localparam int CTRL_REF_EN_POS = 8;
  localparam int CTRL_CS_USE_POS = 9;
  localparam int CTRL_APPEND_POS = 10;
  localparam int CTRL_REL_DELAY_POS = 11;
  localparam int CTRL_REF_LEVEL_POS = 12;
  localparam int CTRL_RDY_ROUTE_POS = 13;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] CTRL_WMASK = 16'hff7f;

  // ----------------------------------------------------------------
  // Error and status fields
  // ----------------------------------------------------------------
  localparam int ERR_WRITE_POS = 0;
  localparam int ERR_READ_POS = 1;
  localparam int ERR_SCLK_CNT_POS = 2;
  localparam logic [2:0] ERR_RESET = 3'h0;
  localparam int STAT_RDY_N_POS = 7;

  typedef enum logic [2:0] {ST_IDLE, ST_CMD, ST_DATA, ST_WAIT, ST_RELEASE} srl_state_t;

  // Payload bits that follow the command byte for one register.
  function automatic logic [5:0] srl_payload_len(input logic [5:0] addr, input logic append);
    case (addr)
      ADDR_CTRL: srl_payload_len = 6'(W_CTRL);
      ADDR_DATA: srl_payload_len = append ? 6'(W_DATA + W_BYTE) : 6'(W_DATA);
      default: srl_payload_len = 6'(W_BYTE);
    endcase
  endfunction : srl_payload_len

endpackage : srl_pkg

// *** design/srl_pin_if.sv ***
/*
  Synchronised serial pin levels and edges passed from the pin synchroniser
  to the framing core. All signals are on the core clock.
*/
`timescale 1ns/1ns
`default_nettype none
interface srl_pin_if;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_rise;
  modport sync (output sclk, cs_n, mosi, sclk_rise, sclk_fall, cs_rise);
  modport core (input sclk, cs_n, mosi, sclk_rise, sclk_fall, cs_rise);
endinterface : srl_pin_if
`default_nettype wire

// *** design/srl_pin_sync.sv ***
/*
  Two-flop synchronisers for SCLK, CS and MOSI with edge detection.
  Assumes the pins are asynchronous to i_clock and SCLK is far slower.
*/
`timescale 1ns/1ns
`default_nettype none
module srl_pin_sync
  import srl_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic i_mosi,
  srl_pin_if.sync pins
);
  // Bit order in each stage: {mosi, cs_n, sclk}. Idle SCLK and CS are high.
  logic [2:0] meta_ff, nxt_meta;
  logic [2:0] sync_ff, nxt_sync;
  logic [1:0] prev_ff, nxt_prev;

  always_comb begin
    nxt_meta = {i_mosi, i_cs_n, i_sclk};
    nxt_sync = meta_ff;
    nxt_prev = sync_ff[1:0];
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      meta_ff <= 3'h3;
      sync_ff <= 3'h3;
      prev_ff <= 2'h3;
    end else begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
      prev_ff <= nxt_prev;
    end
  end

  assign pins.sclk = sync_ff[0];
  assign pins.cs_n = sync_ff[1];
  assign pins.mosi = sync_ff[2];
  assign pins.sclk_rise = sync_ff[0] & ~prev_ff[0];
  assign pins.sclk_fall = ~sync_ff[0] & prev_ff[0];
  assign pins.cs_rise = sync_ff[1] & ~prev_ff[1];
endmodule : srl_pin_sync
`default_nettype wire

// *** design/srl_tx_shift.sv ***
/*
  Left-shifting transmit register for read payloads, MSB first.
  Assumes load and shift are never asserted in the same cycle.
*/
`timescale 1ns/1ns
`default_nettype none
module srl_tx_shift
  import srl_pkg::*;
#(
  parameter int WIDTH = W_SHIFT
) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_load,
  input wire logic [WIDTH-1:0] i_load_val,
  input wire logic i_shift,
  output logic o_msb
);
  generate
    if (WIDTH < 2) begin : g_bad_width
      $error("srl_tx_shift needs WIDTH of at least 2");
    end
  endgenerate

  logic [WIDTH-1:0] sh_ff, nxt_sh;

  always_comb begin
    nxt_sh = sh_ff;
    if (i_load) begin
      nxt_sh = i_load_val;
    end else if (i_shift) begin
      nxt_sh = {sh_ff[WIDTH-2:0], 1'b0};
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      sh_ff <= '0;
    end else begin
      sh_ff <= nxt_sh;
    end
  end

  assign o_msb = sh_ff[WIDTH-1];
endmodule : srl_tx_shift
`default_nettype wire

// *** design/srl_cs_mode_ctrl.sv ***
/*
  Serial port framing for a sigma-delta converter: command decode, the
  converter control word, 3-wire/4-wire framing, output release and the
  shared data/ready output pin.
  Assumes a mode 3 host (SCLK idles high, data changes on the falling edge)
  and a converter core that pulses i_conv_valid with a new result.
*/
// Contract
// - Status append 0 reads the data register alone, 1 appends the status byte.
// - With append on a data read sends 24 data bits then 8 status bits.
// - Bit 9 of the control word is the chip-select use bit and resets to 0.
// - In 3-wire mode the frame ends on its last rising SCLK edge.
// - In 3-wire mode a read's last rising edge releases the pin or turns it to ready.
// - The release delay bit postpones that release after a read.
// - Payloads are 8, 16 or 24 bits and status append lengthens the data read.
// - Even in 3-wire mode CS high tristates the output pin.
// - In 4-wire mode each rising CS edge ends and resets the frame.
// - In 4-wire mode the pin turns to ready signalling once CS falls again after the CS rise ending a read.
// - Write, read and clock count errors are flagged only in 4-wire mode.
// - In 4-wire mode the output is high impedance while CS is high.
// - Bit 8 enables the internal reference; the level select sets the reference pin only while bit 8 is set.
`timescale 1ns/1ns
`default_nettype none
module srl_cs_mode_ctrl
  import srl_pkg::*;
#(
  parameter int REL_CYCLES = REL_CYC
) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic i_mosi,
  input wire logic i_conv_valid,
  input wire logic [W_DATA-1:0] i_conv_data,
  input wire logic [W_BYTE-1:0] i_conv_status,
  output logic o_dout,
  output logic o_dout_oe,
  output logic o_ref_enable,
  output logic o_ref_level,
  output logic [W_CTRL-1:0] o_ctrl_word
);
  generate
    if (REL_CYCLES < 1 || REL_CYCLES > 8) begin : g_bad_rel
      $error("REL_CYCLES must lie in 1..8");
    end
  endgenerate

  // ----------------------------------------------------------------
  // Pin synchronisation and transmit shifter
  // ----------------------------------------------------------------
  srl_pin_if pins ();

  srl_pin_sync u_sync (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_sclk(i_sclk),
    .i_cs_n(i_cs_n),
    .i_mosi(i_mosi),
    .pins(pins)
  );

  logic sh_load;
  logic sh_shift;
  logic sh_msb;
  logic [W_SHIFT-1:0] sh_val;

  srl_tx_shift #(.WIDTH(W_SHIFT)) u_tx (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_load(sh_load),
    .i_load_val(sh_val),
    .i_shift(sh_shift),
    .o_msb(sh_msb)
  );

  // ----------------------------------------------------------------
  // Frame state
  // ----------------------------------------------------------------
  srl_state_t state_ff, nxt_state;
  logic [CMD_BITS-2:0] cmd_ff, nxt_cmd;
  logic [5:0] cnt_ff, nxt_cnt;
  logic [5:0] len_ff, nxt_len;
  logic [5:0] addr_ff, nxt_addr;
  logic rd_ff, nxt_rd;
  logic [W_DATA-1:0] wr_ff, nxt_wr;
  logic [2:0] rel_ff, nxt_rel;
  logic [W_CTRL-1:0] ctrl_ff, nxt_ctrl;
  logic [2:0] err_ff, nxt_err;
  logic [W_DATA-1:0] data_ff, nxt_data;
  logic [W_BYTE-1:0] stat_ff, nxt_stat;
  logic rdy_ff, nxt_rdy;

  logic csen;
  logic append;
  logic route;
  logic rel_delay;
  logic rise;
  logic fall;
  logic cs_end;
  logic cmd_done;
  logic last_bit;
  logic [CMD_BITS-1:0] cmd_full;
  logic [W_DATA-1:0] wr_full;
  logic [W_BYTE-1:0] status_byte;

  assign csen = ctrl_ff[CTRL_CS_USE_POS];
  assign append = ctrl_ff[CTRL_APPEND_POS];
  assign route = ctrl_ff[CTRL_RDY_ROUTE_POS];
  assign rel_delay = ctrl_ff[CTRL_REL_DELAY_POS];
  // In 3-wire mode CS plays no part in framing, only in driving the pin.
  assign rise = pins.sclk_rise && (!csen || !pins.cs_n);
  assign fall = pins.sclk_fall && (!csen || !pins.cs_n);
  assign cs_end = csen && pins.cs_rise;
  assign cmd_full = {cmd_ff, pins.mosi};
  assign wr_full = {wr_ff[W_DATA-2:0], pins.mosi};
  assign cmd_done = (state_ff == ST_CMD) && rise && (cnt_ff == 6'(CMD_BITS - 1));
  assign last_bit = (state_ff == ST_DATA) && rise && (cnt_ff == len_ff - 6'h01);
  assign status_byte = {~rdy_ff, stat_ff[STAT_RDY_N_POS-1:0]};

  always_comb begin
    logic [2:0] err_set;
    err_set = 3'h0;
    nxt_state = state_ff;
    nxt_cmd = cmd_ff;
    nxt_cnt = cnt_ff;
    nxt_len = len_ff;
    nxt_addr = addr_ff;
    nxt_rd = rd_ff;
    nxt_wr = wr_ff;
    nxt_rel = rel_ff;
    nxt_ctrl = ctrl_ff;
    nxt_err = err_ff;
    nxt_data = data_ff;
    nxt_stat = stat_ff;
    nxt_rdy = rdy_ff;
    sh_load = 1'b0;
    sh_shift = 1'b0;
    sh_val = '0;
    case (state_ff)
      ST_IDLE: begin
        if (rise) begin
          nxt_cmd = {cmd_ff[CMD_BITS-3:0], pins.mosi};
          nxt_cnt = 6'h01;
          nxt_state = ST_CMD;
        end
      end
      ST_CMD: begin
        if (rise) begin
          nxt_cmd = {cmd_ff[CMD_BITS-3:0], pins.mosi};
          nxt_cnt = cnt_ff + 6'h01;
        end
        if (cmd_done) begin
          nxt_rd = cmd_full[CMD_READ_POS];
          nxt_addr = cmd_full[5:0];
          nxt_len = srl_payload_len(cmd_full[5:0], append && cmd_full[CMD_READ_POS]);
          nxt_cnt = 6'h00;
          nxt_state = ST_DATA;
          if (cmd_full[CMD_READ_POS]) begin
            sh_load = 1'b1;
            case (cmd_full[5:0])
              ADDR_STATUS: sh_val = {status_byte, 24'h000000};
              ADDR_CTRL: sh_val = {ctrl_ff, 16'h0000};
              ADDR_DATA: sh_val = {data_ff, append ? status_byte : 8'h00};
              ADDR_ERROR: sh_val = {5'h00, err_ff, 24'h000000};
              default: err_set[ERR_READ_POS] = 1'b1;
            endcase
            if (cmd_full[5:0] == ADDR_DATA) begin
              nxt_rdy = 1'b0;
            end
            if (cmd_full[5:0] == ADDR_ERROR) begin
              nxt_err = ERR_RESET;
            end
          end else if (cmd_full[5:0] != ADDR_CTRL) begin
            err_set[ERR_WRITE_POS] = 1'b1;
          end
        end
      end
      ST_DATA: begin
        if (rise) begin
          nxt_wr = wr_full;
          nxt_cnt = cnt_ff + 6'h01;
        end
        if (fall && rd_ff) begin
          sh_shift = 1'b1;
        end
        if (last_bit) begin
          if (!rd_ff && addr_ff == ADDR_CTRL) begin
            nxt_ctrl = wr_full[W_CTRL-1:0] & CTRL_WMASK;
          end
          // The frame length comes from the clock count alone in 3-wire mode.
          if (csen) begin
            nxt_state = ST_WAIT;
          end else if (rd_ff && rel_delay) begin
            nxt_rel = 3'(REL_CYCLES - 1);
            nxt_state = ST_RELEASE;
          end else begin
            nxt_state = ST_IDLE;
          end
        end
      end
      ST_WAIT: begin
        if (rise) begin
          err_set[ERR_SCLK_CNT_POS] = 1'b1;
        end
      end
      ST_RELEASE: begin
        if (rel_ff == 3'h0) begin
          nxt_state = ST_IDLE;
        end else begin
          nxt_rel = rel_ff - 3'h1;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
    if (cs_end) begin
      nxt_state = ST_IDLE;
      if (state_ff == ST_CMD || state_ff == ST_DATA) begin
        err_set[ERR_SCLK_CNT_POS] = 1'b1;
      end
    end
    // Error flags mean nothing without CS framing, so no new flags are set then.
    if (csen) begin
      nxt_err = nxt_err | err_set;
    end
    // A result arriving in the same cycle as a data read wins over the clear.
    if (i_conv_valid) begin
      nxt_data = i_conv_data;
      nxt_stat = i_conv_status;
      nxt_rdy = 1'b1;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      state_ff <= ST_IDLE;
      cmd_ff <= '0;
      cnt_ff <= 6'h00;
      len_ff <= 6'h00;
      addr_ff <= 6'h00;
      rd_ff <= 1'b0;
      wr_ff <= '0;
      rel_ff <= 3'h0;
      ctrl_ff <= CTRL_RESET;
      err_ff <= ERR_RESET;
      data_ff <= '0;
      stat_ff <= '0;
      rdy_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cmd_ff <= nxt_cmd;
      cnt_ff <= nxt_cnt;
      len_ff <= nxt_len;
      addr_ff <= nxt_addr;
      rd_ff <= nxt_rd;
      wr_ff <= nxt_wr;
      rel_ff <= nxt_rel;
      ctrl_ff <= nxt_ctrl;
      err_ff <= nxt_err;
      data_ff <= nxt_data;
      stat_ff <= nxt_stat;
      rdy_ff <= nxt_rdy;
    end
  end

  // ----------------------------------------------------------------
  // Output pin and reference controls
  // ----------------------------------------------------------------
  logic dout_ff, nxt_dout;
  logic oe_ff, nxt_oe;
  logic ref_en_ff, nxt_ref_en;
  logic ref_lvl_ff, nxt_ref_lvl;
  logic [W_CTRL-1:0] ctrl_out_ff;
  logic read_out;

  assign read_out = rd_ff && (state_ff == ST_DATA || state_ff == ST_WAIT ||
                              state_ff == ST_RELEASE);

  always_comb begin
    nxt_dout = dout_ff;
    if (read_out) begin
      if (state_ff == ST_DATA && fall) begin
        nxt_dout = sh_msb;
      end
    end else begin
      nxt_dout = ~rdy_ff;
    end
    // CS high always wins over driving, whatever the wire mode.
    nxt_oe = !pins.cs_n && (read_out || route);
    nxt_ref_en = ctrl_ff[CTRL_REF_EN_POS];
    nxt_ref_lvl = ctrl_ff[CTRL_REF_EN_POS] & ctrl_ff[CTRL_REF_LEVEL_POS];
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      dout_ff <= 1'b1;
      oe_ff <= 1'b0;
      ref_en_ff <= 1'b0;
      ref_lvl_ff <= 1'b0;
      ctrl_out_ff <= CTRL_RESET;
    end else begin
      dout_ff <= nxt_dout;
      oe_ff <= nxt_oe;
      ref_en_ff <= nxt_ref_en;
      ref_lvl_ff <= nxt_ref_lvl;
      ctrl_out_ff <= nxt_ctrl;
    end
  end

  assign o_dout = dout_ff;
  assign o_dout_oe = oe_ff;
  assign o_ref_enable = ref_en_ff;
  assign o_ref_level = ref_lvl_ff;
  assign o_ctrl_word = ctrl_out_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rst_n);

  sequence s_rel_hold;
    (state_ff == ST_RELEASE) [*4];
  endsequence

  chk_ctrl_reset: assert property (
    @(posedge i_clock) disable iff (1'b0) !i_rst_n |=> ctrl_ff == CTRL_RESET)
    else $error("control word not cleared by reset");

  chk_cs_tristate: assert property (pins.cs_n |=> !o_dout_oe)
    else $error("output driven while CS high");

  chk_append_len: assert property (
    cmd_done && cmd_full[CMD_READ_POS] && cmd_full[5:0] == ADDR_DATA
    |=> len_ff == (append ? 6'h20 : 6'h18))
    else $error("data read length wrong for append setting");

  chk_3w_frame_end: assert property (
    last_bit && !csen |=> state_ff == ST_IDLE || state_ff == ST_RELEASE)
    else $error("3-wire frame not ended on last edge");

  chk_3w_release: assert property (
    last_bit && !csen && rd_ff && !rel_delay && !route |=> ##1 !o_dout_oe)
    else $error("output not released after 3-wire read");

  chk_release_delay: assert property (
    last_bit && !csen && rd_ff && rel_delay |=> s_rel_hold ##1 state_ff == ST_IDLE)
    else $error("release delay length wrong");

  chk_4w_cs_reset: assert property (
    cs_end && (state_ff == ST_CMD || state_ff == ST_DATA)
    |=> state_ff == ST_IDLE && err_ff[ERR_SCLK_CNT_POS])
    else $error("CS rise did not reset frame and flag clock count");

  chk_rdy_level: assert property (
    state_ff == ST_IDLE && !pins.cs_n && route
    |=> o_dout_oe && o_dout == !$past(rdy_ff))
    else $error("ready signalling not on output pin");

  chk_err_3wire: assert property (
    !csen |=> !$rose(err_ff[ERR_SCLK_CNT_POS]) && !$rose(err_ff[ERR_WRITE_POS]))
    else $error("error flagged in 3-wire mode");

  chk_ref_follow: assert property (
    ##1 o_ref_enable == $past(ctrl_ff[CTRL_REF_EN_POS]) &&
    (o_ref_level -> o_ref_enable))
    else $error("reference outputs do not follow control word");

endmodule : srl_cs_mode_ctrl
`default_nettype wire

// *** tb/srl_host_model.sv ***
/*
  Behavioural host SPI controller in mode 3, SCLK of eight core cycles.
  Assumes the bench calls its tasks from processes on the core clock.
*/
`timescale 1ns/1ns
`default_nettype none
module srl_host_model (
  input wire logic i_clock,
  input wire logic i_dout,
  input wire logic i_dout_oe,
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_mosi
);
  logic last_ff = 1'b1;
  logic wire_lvl;

  // A released pin shows the inverse of its last level, so a stale bit never matches.
  assign wire_lvl = i_dout_oe ? i_dout : ~last_ff;

  always @(posedge i_clock) begin
    last_ff <= wire_lvl;
  end

  initial begin
    o_sclk = 1'b1;
    o_cs_n = 1'b0;
    o_mosi = 1'b1;
  end

  task automatic set_cs(input logic lvl);
    @(posedge i_clock);
    o_cs_n <= lvl;
  endtask : set_cs

  // The bit count n comes from the caller and need not match what the addressed register needs.
  task automatic xfer(input logic four, input int n, input logic [39:0] wd,
                      output logic [31:0] rd);
    rd = '0;
    repeat (16) @(posedge i_clock);
    o_cs_n <= 1'b0;
    if (four) begin
      repeat (4) @(posedge i_clock);
    end
    for (int i = 0; i < n; i++) begin
      o_sclk <= 1'b0;
      o_mosi <= wd[39-i];
      repeat (4) @(posedge i_clock);
      o_sclk <= 1'b1;
      @(posedge i_clock);
      rd = {rd[30:0], wire_lvl};
      if (i < n - 1) begin
        repeat (3) @(posedge i_clock);
      end
    end
    if (four) begin
      repeat (4) @(posedge i_clock);
      o_cs_n <= 1'b1;
    end
  endtask : xfer
endmodule : srl_host_model
`default_nettype wire

// *** tb/testbench.sv ***
/*
  Self-checking bench for the serial port framing block.
  Assumes the host model drives the pins and the bench plays the converter.
*/
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import srl_pkg::*;
  localparam int REL = REL_CYC;
  typedef struct {logic [15:0] wv; logic [15:0] ev;} srl_row_t;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cv = 1'b0;
  logic [23:0] cd = 24'h000000;
  logic [7:0] cst = 8'h00;
  logic sclk, cs_n, mosi, dout, oe, ref_en, ref_lv;
  logic [15:0] ctrl;
  logic [31:0] r;
  int fail_count = 0;
  int n_checks = 0;
  int cyc = 0;
  srl_row_t rows[4] = '{'{16'h0100, 16'h0100}, '{16'h1100, 16'h1100},
                        '{16'h1000, 16'h1000}, '{16'h04ff, 16'h047f}};

  always #50 clk = ~clk;

  srl_cs_mode_ctrl #(.REL_CYCLES(REL)) dut (.i_clock(clk), .i_rst_n(rst_n),
    .i_sclk(sclk), .i_cs_n(cs_n), .i_mosi(mosi), .i_conv_valid(cv),
    .i_conv_data(cd), .i_conv_status(cst), .o_dout(dout), .o_dout_oe(oe),
    .o_ref_enable(ref_en), .o_ref_level(ref_lv), .o_ctrl_word(ctrl));

  srl_host_model host (.i_clock(clk), .i_dout(dout), .i_dout_oe(oe),
    .o_sclk(sclk), .o_cs_n(cs_n), .o_mosi(mosi));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic wrap_up;
    $display("checks=%0d mismatches=%0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : wrap_up

  task automatic wr_ctrl(input logic four, input logic [15:0] v);
    host.xfer(four, 24, {2'b00, ADDR_CTRL, v, 16'h0000}, r);
  endtask : wr_ctrl

  task automatic rd_reg(input logic four, input logic [5:0] a, input int n);
    host.xfer(four, n, {2'b01, a, 32'h00000000}, r);
  endtask : rd_reg

  task automatic conv(input logic [23:0] d, input logic [7:0] s);
    @(posedge clk);
    cv <= 1'b1;
    cd <= d;
    cst <= s;
    @(posedge clk);
    cv <= 1'b0;
  endtask : conv

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : settle

  // Hang guard, about eight times the expected run length.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      fail_count++;
      wrap_up();
    end
  end

  initial begin
    int d[2];
    settle(4);
    chk(32'(ctrl), 32'(CTRL_RESET));
    chk(32'({oe, ref_en, ref_lv}), 32'h0);
    @(posedge clk);
    rst_n <= 1'b1;
    foreach (rows[k]) begin
      wr_ctrl(1'b0, rows[k].wv);
      rd_reg(1'b0, ADDR_CTRL, 24);
      settle(1);
      chk(32'(r[15:0]), 32'(rows[k].ev));
      chk(32'(ctrl), 32'(rows[k].ev));
      chk(32'(ref_en), 32'(rows[k].wv[8]));
      chk(32'(ref_lv), 32'(rows[k].wv[8] & rows[k].wv[12]));
    end
    wr_ctrl(1'b0, 16'h0000);
    conv(24'habcdef, 8'h25);
    rd_reg(1'b0, ADDR_DATA, 32);
    chk(32'(r[23:0]), 32'h00abcdef);
    wr_ctrl(1'b0, 16'h0400);
    conv(24'h123456, 8'hc3);
    rd_reg(1'b0, ADDR_DATA, 40);
    chk(r, 32'h12345643);
    for (int m = 0; m < 2; m++) begin
      wr_ctrl(1'b0, (m == 1) ? 16'h0800 : 16'h0000);
      rd_reg(1'b0, ADDR_CTRL, 24);
      d[m] = 0;
      while (oe === 1'b1 && d[m] < 40) begin
        @(posedge clk);
        d[m]++;
      end
    end
    chk(32'(d[0] < 12), 32'h1);
    chk(32'(d[1] >= d[0] + REL && d[1] <= d[0] + REL + 1), 32'h1);
    wr_ctrl(1'b0, 16'h2000);
    rd_reg(1'b0, ADDR_DATA, 32);
    settle(8);
    chk(32'({oe, dout}), 32'h3);
    conv(24'h000001, 8'h00);
    settle(6);
    chk(32'({oe, dout}), 32'h2);
    host.set_cs(1'b1);
    settle(6);
    chk(32'(oe), 32'h0);
    wr_ctrl(1'b0, 16'h2200);
    host.set_cs(1'b1);
    settle(6);
    chk(32'(oe), 32'h0);
    host.xfer(1'b1, 16, {2'b00, ADDR_STATUS, 32'h55000000}, r);
    rd_reg(1'b1, ADDR_ERROR, 16);
    chk(32'(r[7:0]), 32'h01);
    host.xfer(1'b1, 12, {2'b00, ADDR_CTRL, 32'hffff0000}, r);
    rd_reg(1'b1, ADDR_ERROR, 16);
    chk(32'(r[7:0]), 32'h04);
    chk(32'(ctrl), 32'h2200);
    conv(24'h00beef, 8'h00);
    rd_reg(1'b1, ADDR_DATA, 32);
    chk(32'(r[23:0]), 32'h0000beef);
    settle(6);
    chk(32'(oe), 32'h0);
    conv(24'h000002, 8'h00);
    host.set_cs(1'b0);
    settle(8);
    chk(32'({oe, dout}), 32'h2);
    @(posedge clk);
    rst_n <= 1'b0;
    settle(4);
    chk(32'(ctrl), 32'(CTRL_RESET));
    chk(32'({oe, dout}), 32'h1);
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
